// *** hdl/ldcl_regs.svh ***
// constants of the led driver control logic: sub-addresses, fields, resets, timing
`ifndef LDCL_REGS_SVH
`define LDCL_REGS_SVH

// sub-address codes, low three bits only
`define LDCL_SUB_NONE 3'h0
`define LDCL_SUB_RED_GRN 3'h1
`define LDCL_SUB_BLUE_AUX 3'h2
`define LDCL_SUB_MAIN 3'h3
`define LDCL_SUB_SECONDARY 3'h4
`define LDCL_SUB_AUX_ROUTE 3'h5
`define LDCL_SUB_CAMERA 3'h6
`define LDCL_SUB_OPTIONS 3'h7
`define LDCL_SUB_BITS 3

// reset value of every staged and loaded register
`define LDCL_REG_RESET 8'h00

// options register fields
`define LDCL_OPT_GATE_TGT 1
`define LDCL_OPT_CAM_OVR 2
`define LDCL_OPT_DROP_MASK 3
`define LDCL_OPT_FORCE_HALF 6
`define LDCL_OPT_FORCE_DOUBLE 7

// aux routing codes, two bits per aux output
`define LDCL_ROUTE_AUX 2'h0
`define LDCL_ROUTE_MAIN 2'h1
`define LDCL_ROUTE_SUB 2'h2
`define LDCL_ROUTE_CAM 2'h3

// serial port
`define LDCL_SLAVE_ADDR 7'h1A
`define LDCL_BYTE_BITS 4'h8

// dropout delay: 400 us at 25 MHz, rounded down as a longest time
`define LDCL_CLK_KHZ 25000
`define LDCL_DROP_DELAY_US 400
`define LDCL_DROP_DELAY_CYC (`LDCL_DROP_DELAY_US * `LDCL_CLK_KHZ / 1000)

`endif

// *** hdl/ldcl_pkg.sv ***
// types shared by the led driver control logic
package ldcl_pkg;

   typedef enum logic [1:0] {
      PUMP_ONE,
      PUMP_ONE_HALF,
      PUMP_DOUBLE
   } ldcl_pump_mode_t;

   typedef enum logic [2:0] {
      SER_IDLE,
      SER_ADDR,
      SER_SUB,
      SER_DATA,
      SER_SKIP
   } ldcl_ser_state_t;

endpackage

// *** hdl/ldcl_sync.sv ***
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module ldcl_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule // ldcl_sync

// *** hdl/ldcl_pump.sv ***
// charge-pump mode stepping on sustained dropout, with forced modes
`timescale 1ns/1ns
module ldcl_pump #(
   parameter int unsigned DELAY_CYC = 10000
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // control
   input wire logic drop_i,
   input wire logic run_i,
   input wire logic mode_rst_i,
   input wire logic force_double_i,
   input wire logic force_half_i,
   // mode
   output ldcl_pkg::ldcl_pump_mode_t mode_o
);
   localparam int CW = $clog2(DELAY_CYC + 1);
   localparam logic [CW-1:0] LIM = CW'(DELAY_CYC - 1);

   ldcl_pkg::ldcl_pump_mode_t auto_ff;
   ldcl_pkg::ldcl_pump_mode_t nxt_auto;
   ldcl_pkg::ldcl_pump_mode_t nxt_mode;
   ldcl_pkg::ldcl_pump_mode_t mode_ff;
   logic [CW-1:0] cnt_ff;

   wire counting = drop_i & run_i & (auto_ff != ldcl_pkg::PUMP_DOUBLE);
   wire expired = counting & (cnt_ff == LIM);

   always_comb begin
      case (auto_ff)
         ldcl_pkg::PUMP_ONE: nxt_auto = ldcl_pkg::PUMP_ONE_HALF;
         ldcl_pkg::PUMP_ONE_HALF: nxt_auto = ldcl_pkg::PUMP_DOUBLE;
         default: nxt_auto = ldcl_pkg::PUMP_DOUBLE;
      endcase
   end

   // force double wins over force one-and-half
   assign nxt_mode = force_double_i ? ldcl_pkg::PUMP_DOUBLE :   // R23
                     force_half_i ? ldcl_pkg::PUMP_ONE_HALF : auto_ff;

   // any gap in dropout restarts the delay
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         auto_ff <= ldcl_pkg::PUMP_ONE;
         cnt_ff <= '0;
         mode_ff <= ldcl_pkg::PUMP_ONE;
      end else begin
         mode_ff <= nxt_mode;
         if (mode_rst_i) begin
            auto_ff <= ldcl_pkg::PUMP_ONE;   // R21
            cnt_ff <= '0;
         end else if (expired) begin
            auto_ff <= nxt_auto;   // R20
            cnt_ff <= '0;
         end else if (counting) begin
            cnt_ff <= cnt_ff + 1'b1;   // R25
         end else begin
            cnt_ff <= '0;
         end
      end
   end

   assign mode_o = mode_ff;

   a_mode_to_one: assert property ( // R21
      @(posedge core_clk_i) disable iff (reset_i)
      mode_rst_i |=> auto_ff == ldcl_pkg::PUMP_ONE)
      else $error("pump mode not returned to 1x");
   a_step_on_expiry: assert property ( // R20
      @(posedge core_clk_i) disable iff (reset_i)
      (expired && !mode_rst_i && auto_ff == ldcl_pkg::PUMP_ONE)
      |=> auto_ff == ldcl_pkg::PUMP_ONE_HALF)
      else $error("pump did not step to 1.5x after dropout delay");
   a_hold_without_cause: assert property ( // R25
      @(posedge core_clk_i) disable iff (reset_i)
      (!mode_rst_i && !expired) |=> $stable(auto_ff))
      else $error("pump mode changed without cause");
   a_force_double: assert property ( // R23
      @(posedge core_clk_i) disable iff (reset_i)
      force_double_i |=> mode_o == ldcl_pkg::PUMP_DOUBLE)
      else $error("forced double mode not applied");
endmodule // ldcl_pump

// *** hdl/ldcl_top.sv ***
// led driver control logic: serial write port, staged and loaded levels, gating, pump mode
//
// How it works
// R1 - serial data sampled on clock rise, msb first, lsb last
// R2 - address, sub-address and seven data registers
// R3 - ack after address, then sub-address byte, then data byte to that register
// R4 - after stop a load pulse copies all staged registers to loaded ones
// R5 - host may write several registers before stop so all change together
// R6 - static port logic, no minimum serial clock rate, no timeout
// R7 - shutdown when no source enabled or logic supply undervoltage
// R8 - main and secondary banks use 8-bit codes, zero disables bank
// R9 - camera bank uses 4-bit code, zero disables bank
// R10 - red, green, blue each 4-bit code, each off when zero
// R11 - each aux output routed to aux, camera, secondary or main code
// R12 - aux block off only when routing and aux field are both zero
// R13 - dropout mask ignores fourth aux and rgb dropout
// R14 - camera select low picks low field, high picks high field
// R15 - gate target bit: 0 gates rgb, 1 gates secondary display
// R16 - gate high lights selected display, low turns it off
// R17 - gate has no effect on the unselected display
// R18 - overtemperature disables all sources and the pump until cooled
// R19 - current-set fault disables all sources and the pump
// R20 - pump steps 1x to 1.5x to 2x after dropout delay
// R21 - pump returns to 1x on level write or camera select fall
// R22 - low three sub-address bits select register; zero selects none
// R23 - force double holds 2x over force one-and-half, else dropout logic
// R24 - camera override uses high field and ignores camera select
// R25 - dropout must last the whole delay; 2x holds until reset event
`timescale 1ns/1ns
`include "ldcl_regs.svh"
module ldcl_top #(
   parameter logic [6:0] SLAVE_ADDR = `LDCL_SLAVE_ADDR,
   parameter int unsigned DROP_DELAY_CYC = `LDCL_DROP_DELAY_CYC
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // serial port pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // control pins and analog status
   input wire logic undervoltage_lockout_i,
   input wire logic cam_level_select_i,
   input wire logic display_gate_input_i,
   input wire logic overtemp_i,
   input wire logic current_set_fault_i,
   // dropout flags from current sources
   input wire logic [3:0] drop_main_i,
   input wire logic [1:0] drop_sub_i,
   input wire logic [2:0] drop_rgb_i,
   input wire logic [3:0] drop_cam_i,
   input wire logic [3:0] drop_aux_i,
   // level codes to the current sources
   output logic [7:0] main_code_o,
   output logic [7:0] sub_code_o,
   output logic [3:0] red_code_o,
   output logic [3:0] green_code_o,
   output logic [3:0] blue_code_o,
   output logic [3:0] cam_code_o,
   output logic [31:0] aux_code_o,
   // source enables and chip state
   output logic main_en_o,
   output logic sub_en_o,
   output logic red_en_o,
   output logic green_en_o,
   output logic blue_en_o,
   output logic cam_en_o,
   output logic [3:0] aux_en_o,
   output logic shutdown_o,
   output logic pump_en_o,
   output ldcl_pkg::ldcl_pump_mode_t pump_mode_o
);
   // synchronised pins
   logic [23:0] pin_s;
   logic scl_s, sda_s, undervoltage_lockout_s, cam_sel_s, gate_s, overtemp_s, rset_fault_s;
   logic [16:0] drop_s;

   ldcl_sync #(.W(24)) u_sync (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .async_i({drop_aux_i, drop_cam_i, drop_rgb_i, drop_sub_i, drop_main_i,
                current_set_fault_i, overtemp_i, display_gate_input_i,
                cam_level_select_i, undervoltage_lockout_i, sda_i, scl_i}),
      .sync_o(pin_s)
   );

   assign {drop_s, rset_fault_s, overtemp_s, gate_s, cam_sel_s, undervoltage_lockout_s, sda_s, scl_s} = pin_s;

   // serial receiver
   logic scl_q_ff, sda_q_ff, cam_sel_q_ff;
   ldcl_pkg::ldcl_ser_state_t state_ff;
   logic [3:0] bitcnt_ff;
   logic [7:0] shift_ff;
   logic [2:0] sub_ff;
   logic ack_ff, wr_stb_ff, pend_ff, load_ff, sda_out_ff;

   wire scl_rise = scl_s & ~scl_q_ff;
   wire scl_fall = ~scl_s & scl_q_ff;
   wire start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   wire stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
   wire receiving = (state_ff == ldcl_pkg::SER_ADDR) | (state_ff == ldcl_pkg::SER_SUB) |
                    (state_ff == ldcl_pkg::SER_DATA);
   wire take_bit = scl_rise & ~ack_ff & receiving;
   wire byte_done = scl_fall & ~ack_ff & (bitcnt_ff == `LDCL_BYTE_BITS);
   wire addr_hit = (shift_ff[7:1] == SLAVE_ADDR) & ~shift_ff[0];
   wire sub_valid = sub_ff != `LDCL_SUB_NONE;   // R22

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_q_ff <= 1'b0;
         sda_q_ff <= 1'b0;
         cam_sel_q_ff <= 1'b0;
      end else begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
         cam_sel_q_ff <= cam_sel_s;
      end
   end

   // no timeout anywhere: state simply waits for the next edge
   always_ff @(posedge core_clk_i or posedge reset_i) begin   // R6
      if (reset_i) begin
         state_ff <= ldcl_pkg::SER_IDLE;
         bitcnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         sub_ff <= 3'h0;
         ack_ff <= 1'b0;
         wr_stb_ff <= 1'b0;
         pend_ff <= 1'b0;
         load_ff <= 1'b0;
      end else begin
         wr_stb_ff <= 1'b0;
         load_ff <= 1'b0;
         if (undervoltage_lockout_s) begin
            state_ff <= ldcl_pkg::SER_IDLE;
            ack_ff <= 1'b0;
            pend_ff <= 1'b0;
         end else if (start_det) begin
            state_ff <= ldcl_pkg::SER_ADDR;
            bitcnt_ff <= 4'h0;
            ack_ff <= 1'b0;
         end else if (stop_det) begin
            state_ff <= ldcl_pkg::SER_IDLE;
            ack_ff <= 1'b0;
            load_ff <= pend_ff;   // R4
            pend_ff <= 1'b0;
         end else begin
            if (take_bit) begin
               shift_ff <= {shift_ff[6:0], sda_s};   // R1
               bitcnt_ff <= bitcnt_ff + 4'h1;
            end
            if (scl_fall & ack_ff) begin
               ack_ff <= 1'b0;
            end
            if (byte_done) begin
               bitcnt_ff <= 4'h0;
               case (state_ff)
                  ldcl_pkg::SER_ADDR: begin
                     ack_ff <= addr_hit;   // R3
                     state_ff <= addr_hit ? ldcl_pkg::SER_SUB : ldcl_pkg::SER_SKIP;
                  end
                  ldcl_pkg::SER_SUB: begin
                     sub_ff <= shift_ff[`LDCL_SUB_BITS-1:0];   // R22
                     ack_ff <= 1'b1;
                     state_ff <= ldcl_pkg::SER_DATA;
                  end
                  ldcl_pkg::SER_DATA: begin
                     ack_ff <= 1'b1;
                     wr_stb_ff <= sub_valid;
                     pend_ff <= pend_ff | sub_valid;   // R5
                     state_ff <= ldcl_pkg::SER_SUB;
                  end
                  default: begin
                     state_ff <= state_ff;
                  end
               endcase
            end
         end
      end
   end

   // staged and loaded registers, undervoltage clears both
   logic [7:0] stage_ff [1:7];
   logic [7:0] dac_ff [1:7];

   generate
      for (genvar r = 1; r <= 7; r++) begin : g_reg   // R2
         always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
               stage_ff[r] <= `LDCL_REG_RESET;
               dac_ff[r] <= `LDCL_REG_RESET;
            end else if (undervoltage_lockout_s) begin
               stage_ff[r] <= `LDCL_REG_RESET;
               dac_ff[r] <= `LDCL_REG_RESET;
            end else begin
               if (wr_stb_ff && sub_ff == 3'(r)) begin
                  stage_ff[r] <= shift_ff;   // R3
               end
               if (load_ff) begin
                  dac_ff[r] <= stage_ff[r];   // R4
               end
            end
         end
      end
   endgenerate

   // decoded fields of the loaded registers
   wire [3:0] red_lvl = dac_ff[`LDCL_SUB_RED_GRN][3:0];
   wire [3:0] grn_lvl = dac_ff[`LDCL_SUB_RED_GRN][7:4];
   wire [3:0] blu_lvl = dac_ff[`LDCL_SUB_BLUE_AUX][3:0];
   wire [3:0] aux_lvl = dac_ff[`LDCL_SUB_BLUE_AUX][7:4];
   wire [7:0] main_lvl = dac_ff[`LDCL_SUB_MAIN];
   wire [7:0] sub_lvl = dac_ff[`LDCL_SUB_SECONDARY];
   wire [7:0] aux_route = dac_ff[`LDCL_SUB_AUX_ROUTE];
   wire [7:0] cam_reg = dac_ff[`LDCL_SUB_CAMERA];
   wire [7:0] opts = dac_ff[`LDCL_SUB_OPTIONS];

   wire cam_hi = opts[`LDCL_OPT_CAM_OVR] | cam_sel_s;   // R24
   wire [3:0] cam_lvl = cam_hi ? cam_reg[7:4] : cam_reg[3:0];   // R14
   wire gate_sub = opts[`LDCL_OPT_GATE_TGT];   // R15
   wire rgb_gate = gate_sub | gate_s;   // R17
   wire sub_gate = ~gate_sub | gate_s;   // R16
   wire fault = overtemp_s | rset_fault_s;   // R18

   wire main_on = |main_lvl;   // R8
   wire sub_on = (|sub_lvl) & sub_gate;
   wire red_on = (|red_lvl) & rgb_gate;   // R10
   wire grn_on = (|grn_lvl) & rgb_gate;
   wire blu_on = (|blu_lvl) & rgb_gate;
   wire cam_on = |cam_lvl;   // R9
   wire aux_blk_on = (|aux_route) | (|aux_lvl);   // R12

   logic [31:0] nxt_aux_code;
   logic [3:0] aux_on;

   generate
      for (genvar a = 0; a < 4; a++) begin : g_aux
         wire [1:0] sel = aux_route[2*a+1:2*a];
         assign nxt_aux_code[8*a+7:8*a] =
            (sel == `LDCL_ROUTE_MAIN) ? main_lvl :   // R11
            (sel == `LDCL_ROUTE_SUB) ? sub_lvl :
            (sel == `LDCL_ROUTE_CAM) ? {4'h0, cam_lvl} : {4'h0, aux_lvl};
         assign aux_on[a] = aux_blk_on & (|nxt_aux_code[8*a+7:8*a]);
      end
   endgenerate

   wire any_on = main_on | sub_on | red_on | grn_on | blu_on | cam_on | (|aux_on);
   wire nxt_shutdown = ~any_on | undervoltage_lockout_s;   // R7
   wire live = ~nxt_shutdown & ~fault;   // R19

   // dropout from enabled sources only; mask drops rgb and fourth aux
   logic [16:0] en_vec;
   wire [16:0] drop_mask = opts[`LDCL_OPT_DROP_MASK] ? 17'h0FE3F : 17'h1FFFF;   // R13
   wire drop_any = |(drop_s & en_vec & drop_mask);
   wire cam_sel_fall = cam_sel_q_ff & ~cam_sel_s;
   wire lvl_write = wr_stb_ff & (sub_ff != `LDCL_SUB_OPTIONS);
   wire mode_rst = lvl_write | cam_sel_fall | undervoltage_lockout_s;   // R21

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         main_code_o <= 8'h00;
         sub_code_o <= 8'h00;
         red_code_o <= 4'h0;
         green_code_o <= 4'h0;
         blue_code_o <= 4'h0;
         cam_code_o <= 4'h0;
         aux_code_o <= 32'h00000000;
      end else begin
         main_code_o <= main_lvl;
         sub_code_o <= sub_lvl;
         red_code_o <= red_lvl;
         green_code_o <= grn_lvl;
         blue_code_o <= blu_lvl;
         cam_code_o <= cam_lvl;
         aux_code_o <= nxt_aux_code;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         en_vec <= 17'h00000;
         shutdown_o <= 1'b1;
         pump_en_o <= 1'b0;
         sda_out_ff <= 1'b0;
      end else begin
         en_vec <= {{4{live}} & aux_on, {4{live & cam_on}}, live & blu_on, live & grn_on,
                    live & red_on, {2{live & sub_on}}, {4{live & main_on}}};
         shutdown_o <= nxt_shutdown;
         pump_en_o <= live;   // R18
         sda_out_ff <= 1'b0;
      end
   end

   assign main_en_o = en_vec[0];
   assign sub_en_o = en_vec[4];
   assign red_en_o = en_vec[6];
   assign green_en_o = en_vec[7];
   assign blue_en_o = en_vec[8];
   assign cam_en_o = en_vec[9];
   assign aux_en_o = en_vec[16:13];
   assign sda_o = sda_out_ff;
   assign sda_oe_o = ack_ff;

   ldcl_pump #(.DELAY_CYC(DROP_DELAY_CYC)) u_pump (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .drop_i(drop_any),   // R20
      .run_i(pump_en_o),
      .mode_rst_i(mode_rst),
      .force_double_i(opts[`LDCL_OPT_FORCE_DOUBLE]),
      .force_half_i(opts[`LDCL_OPT_FORCE_HALF]),
      .mode_o(pump_mode_o)
   );

   a_msb_first_shift: assert property ( // R1
      @(posedge core_clk_i) disable iff (reset_i)
      (take_bit && !start_det && !stop_det && !undervoltage_lockout_s) |=> shift_ff[0] == $past(sda_s))
      else $error("serial bit not shifted in at lsb end");
   a_ack_on_address: assert property ( // R3
      @(posedge core_clk_i) disable iff (reset_i)
      (byte_done && state_ff == ldcl_pkg::SER_ADDR && addr_hit && !start_det && !stop_det
       && !undervoltage_lockout_s) |=> sda_oe_o && state_ff == ldcl_pkg::SER_SUB)
      else $error("address byte not acknowledged");
   a_load_after_stop: assert property ( // R4
      @(posedge core_clk_i) disable iff (reset_i)
      (stop_det && pend_ff && !undervoltage_lockout_s) |=> load_ff ##1 dac_ff[1] == $past(stage_ff[1]))
      else $error("load pulse missing after stop");
   a_levels_held: assert property ( // R4
      @(posedge core_clk_i) disable iff (reset_i)
      (!load_ff && !undervoltage_lockout_s) |=> $stable(dac_ff[`LDCL_SUB_MAIN]))
      else $error("loaded level changed without load pulse");
   a_sub_none_ignored: assert property ( // R22
      @(posedge core_clk_i) disable iff (reset_i)
      (wr_stb_ff == 1'b0 || sub_ff != 3'h1) && !undervoltage_lockout_s |=> $stable(stage_ff[1]))
      else $error("staged register written without its sub-address");
   a_undervoltage_lockout_shutdown: assert property ( // R7
      @(posedge core_clk_i) disable iff (reset_i)
      undervoltage_lockout_s |=> shutdown_o && !main_en_o && aux_en_o == 4'h0)
      else $error("undervoltage did not shut down");
   a_main_zero_off: assert property ( // R8
      @(posedge core_clk_i) disable iff (reset_i)
      main_lvl == 8'h00 |=> !main_en_o)
      else $error("main bank enabled with zero code");
   a_gate_rgb_off: assert property ( // R16
      @(posedge core_clk_i) disable iff (reset_i)
      (!gate_sub && !gate_s) |=> !red_en_o && !green_en_o && !blue_en_o)
      else $error("rgb lit while gated off");
   a_cam_field_pick: assert property ( // R14
      @(posedge core_clk_i) disable iff (reset_i)
      (!opts[`LDCL_OPT_CAM_OVR] && !cam_sel_s) |=> cam_code_o == $past(cam_reg[3:0]))
      else $error("camera low field not selected");
   a_fault_all_off: assert property ( // R19
      @(posedge core_clk_i) disable iff (reset_i)
      fault |=> !pump_en_o && en_vec == 17'h00000)
      else $error("sources or pump on during fault");
   a_drop_masked: assert property ( // R13
      @(posedge core_clk_i) disable iff (reset_i)
      (opts[`LDCL_OPT_DROP_MASK] && (drop_s[5:0] & en_vec[5:0]) == 6'h00
       && (drop_s[15:9] & en_vec[15:9]) == 7'h00) |-> !drop_any)
      else $error("masked dropout reached the pump");
endmodule // ldcl_top

// *** bench/ldcl_host.sv ***
// i2c host model that writes the led driver over its serial pins
`timescale 1ns/1ns
module ldcl_host (
   // pacing clock
   input wire logic clk_i,
   // open-drain serial pins
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // quarter of the 320 ns link period
   task automatic q();
      repeat (2) @(posedge clk_i);
      #2;
   endtask
   task automatic start();
      sda_low_o = 1'b1;
      q();
      q();
      scl_o = 1'b0;
      q();
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low_o = ~b[i];
         q();
         scl_o = 1'b1;
         q();
         q();
         scl_o = 1'b0;
         q();
      end
      sda_low_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      ack = ~sda_i;
      q();
      scl_o = 1'b0;
      // stretched low so the release of the ack settles first
      q();
      q();
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      q();
      sda_low_o = 1'b0;
      q();
      q();
   endtask
endmodule // ldcl_host

// *** bench/testbench.sv ***
// self-checking bench for the led driver control logic
`timescale 1ns/1ns
`include "ldcl_regs.svh"
module testbench;
   localparam int unsigned DLY = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sda_low, sda, sda_oe, sda_d, nack;
   logic uv = 1'b0, csel = 1'b0, gate = 1'b1, ot = 1'b0, fault = 1'b0;
   logic [3:0] dmain = 4'h0;
   logic [3:0] daux = 4'h0;
   logic [2:0] drgb = 3'h0;
   logic [7:0] main_c, sub_c;
   logic [3:0] red_c, grn_c, blu_c, cam_c, aux_en;
   logic [31:0] aux_c;
   logic main_en, sub_en, red_en, grn_en, blu_en, cam_en, shdn, pump_en;
   ldcl_pkg::ldcl_pump_mode_t mode;
   int failures = 0;
   int check_count = 0;
   // pull-up on the data line; while enabled the device drives its sda_o level
   assign sda = ~(sda_low | (sda_oe & ~sda_d));
   always #20 clk = ~clk;
   ldcl_host host_u (.clk_i(clk), .scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
   ldcl_top #(.DROP_DELAY_CYC(DLY)) dut_u (
      .core_clk_i(clk), .reset_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_d),
      .sda_oe_o(sda_oe), .undervoltage_lockout_i(uv), .cam_level_select_i(csel),
      .display_gate_input_i(gate), .overtemp_i(ot), .current_set_fault_i(fault),
      .drop_main_i(dmain), .drop_sub_i(2'h0), .drop_rgb_i(drgb), .drop_cam_i(4'h0),
      .drop_aux_i(daux), .main_code_o(main_c), .sub_code_o(sub_c), .red_code_o(red_c),
      .green_code_o(grn_c), .blue_code_o(blu_c), .cam_code_o(cam_c), .aux_code_o(aux_c),
      .main_en_o(main_en), .sub_en_o(sub_en), .red_en_o(red_en), .green_en_o(grn_en),
      .blue_en_o(blu_en), .cam_en_o(cam_en), .aux_en_o(aux_en), .shutdown_o(shdn),
      .pump_en_o(pump_en), .pump_mode_o(mode));
   task automatic end_sim();
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic tx(input logic [7:0] b);
      logic a;
      host_u.send(b, a);
      chk("ack", a, 1'b1);
   endtask
   task automatic wr(input logic [7:0] s, input logic [7:0] d);
      host_u.start();
      tx({`LDCL_SLAVE_ADDR, 1'b0});
      tx(s);
      tx(d);
      host_u.stop();
      cyc(8);
   endtask
   task automatic wait_mode(input ldcl_pkg::ldcl_pump_mode_t e, input int lim);
      int n;
      n = 0;
      while (mode !== e && n < lim) begin
         cyc(1);
         n++;
      end
      chk("pump_mode", mode, e);
      if (mode !== e) end_sim();
   endtask
   initial begin
      cyc(3);
      rst = 1'b0;
      cyc(6);
      chk("shutdown", shdn, 1'b1);
      chk("pump_mode", mode, ldcl_pkg::PUMP_ONE);
      // two registers and a dropped one in one frame, clock paused mid-frame
      host_u.start();
      tx({`LDCL_SLAVE_ADDR, 1'b0});
      tx(8'hF3);
      tx(8'hA5);
      cyc(400);
      chk("main_code", main_c, 8'h00);
      tx(8'h04);
      tx(8'h3C);
      tx(8'h00);
      tx(8'hFF);
      host_u.stop();
      cyc(8);
      chk("main_code", main_c, 8'hA5);
      chk("sub_code", sub_c, 8'h3C);
      chk("red_code", red_c, 4'h0);
      chk("shutdown", shdn, 1'b0);
      // read bit gets no ack and the rest of the frame is ignored
      host_u.start();
      host_u.send({`LDCL_SLAVE_ADDR, 1'b1}, nack);
      chk("nack", nack, 1'b0);
      host_u.send(8'h03, nack);
      host_u.send(8'h00, nack);
      host_u.stop();
      cyc(8);
      chk("main_code", main_c, 8'hA5);
      wr(8'h03, 8'h00);
      chk("main_en", {main_en, sub_en}, 2'b01);
      wr(8'h01, 8'h21);
      chk("rgb_code", {grn_c, red_c}, 8'h21);
      chk("rgb_en", {red_en, grn_en, blu_en}, 3'b110);
      gate = 1'b0;
      cyc(5);
      chk("gated", {red_en, grn_en, sub_en}, 3'b001);
      wr(8'h07, 8'h02);
      chk("gated", {red_en, grn_en, sub_en}, 3'b110);
      gate = 1'b1;
      cyc(5);
      chk("gated", sub_en, 1'b1);
      wr(8'h06, 8'h5A);
      chk("cam", {cam_en, cam_c}, 5'h1A);
      csel = 1'b1;
      cyc(5);
      chk("cam_code", cam_c, 4'h5);
      csel = 1'b0;
      wr(8'h07, 8'h04);
      chk("cam_code", cam_c, 4'h5);
      wr(8'h02, 8'h70);
      wr(8'h05, 8'hE4);
      chk("aux_code", aux_c, 32'h053C0007);
      chk("aux_en", aux_en, 4'hD);
      chk("blue", {blu_en, blu_c}, 5'h00);
      // pump steps on held dropout of an enabled bank
      wr(8'h03, 8'h10);
      dmain = 4'h1;
      cyc(DLY - 4);
      chk("pump_mode", mode, ldcl_pkg::PUMP_ONE);
      wait_mode(ldcl_pkg::PUMP_ONE_HALF, 40);
      wait_mode(ldcl_pkg::PUMP_DOUBLE, 40);
      cyc(60);
      chk("pump_mode", mode, ldcl_pkg::PUMP_DOUBLE);
      dmain = 4'h0;
      wr(8'h03, 8'h11);
      chk("pump_mode", mode, ldcl_pkg::PUMP_ONE);
      dmain = 4'h1;
      wait_mode(ldcl_pkg::PUMP_ONE_HALF, 40);
      dmain = 4'h0;
      csel = 1'b1;
      cyc(5);
      csel = 1'b0;
      wait_mode(ldcl_pkg::PUMP_ONE, 10);
      wr(8'h07, 8'hC4);
      wait_mode(ldcl_pkg::PUMP_DOUBLE, 10);
      wr(8'h07, 8'h44);
      wait_mode(ldcl_pkg::PUMP_ONE_HALF, 10);
      // masked rgb and fourth aux dropout must not step the pump
      wr(8'h07, 8'h0C);
      drgb = 3'h1;
      daux = 4'h8;
      cyc(2 * DLY);
      chk("pump_mode", mode, ldcl_pkg::PUMP_ONE);
      wr(8'h07, 8'h04);
      wait_mode(ldcl_pkg::PUMP_ONE_HALF, 40);
      drgb = 3'h0;
      daux = 4'h0;
      ot = 1'b1;
      cyc(5);
      chk("overtemp", {main_en, pump_en}, 2'b00);
      ot = 1'b0;
      fault = 1'b1;
      cyc(5);
      chk("fault", {main_en, pump_en}, 2'b00);
      fault = 1'b0;
      uv = 1'b1;
      cyc(6);
      chk("undervoltage", {shdn, main_c}, {1'b1, 8'h00});
      end_sim();
   end
endmodule // testbench
